// ### bench/dss_dpll_ctrl_tb.sv
// Self-checking bench for the loop status and hitless control block
`timescale 1ns/1ns
module dss_dpll_ctrl_tb;
	import dss_pkg::*;
	localparam int HOLD = 20;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [1:0] mode_req = 2'b00;
	logic [1:0] prof_req = 2'b00;
	logic hitless_switch_select = 1'b0;
	wire logic [31:0] prdata;
	wire logic pready, pslverr, lock, hold, fa, fb, fc, hiz, irq;
	wire logic [2:0] refs;
	wire logic [1:0] mode_w, prof_w;
	int fail_count = 0;
	int cmp_count = 0;
	logic [31:0] rd;
	logic err;
	logic [31:0] corr0;

	always #5 clk_i = ~clk_i;

	dss_ref_model u_dss_ref_model (.clk_i(clk_i), .rstn_i(rstn_i), .per_a_i(16'h30d4), .per_b_i(16'h30e0),
		.per_c_i(16'h30d4), .step_c_i(16'h0005), .mode_req_i(mode_req), .prof_req_i(prof_req),
		.ref_o(refs), .mode_o(mode_w), .prof_o(prof_w));

	dss_dpll_ctrl #(.RESET_HOLD_CYC(HOLD)) u_dss_dpll_ctrl (.clk_i(clk_i), .rstn_i(rstn_i),
		.paddr_i(paddr), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.timing_input_a_i(refs[0]), .timing_input_b_i(refs[1]), .timing_input_c_i(refs[2]),
		.operating_mode_bit0_i(mode_w[0]), .operating_mode_bit1_i(mode_w[1]),
		.application_profile_select_i(prof_w), .hitless_switch_select_i(hitless_switch_select),
		.lock_o(lock), .holdover_o(hold), .input_a_failure_flag_o(fa), .input_b_failure_flag_o(fb),
		.input_c_failure_flag_o(fc), .clk_outputs_hiz_o(hiz), .irq_o(irq));

	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task end_of_test;
		if (fail_count == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= wr;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		// Request held until the rising edge that sees pready high
		@(posedge clk_i);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge clk_i);
			n++;
		end
		if (n == 50) begin
			fail_count++;
		end
		// Answer taken at the completing edge, then the request is dropped
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task cyc(input int n);
		repeat (n) @(negedge clk_i);
	endtask

	task t_reset;
		@(negedge clk_i);
		chk({28'h0, hiz, fc, fb, fa}, 32'hf);
		chk({30'h0, lock, hold}, 32'h0);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd, 32'h0000_081c);
		apb(1'b0, 8'h14, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		cyc(4);
		chk({31'h0, hiz}, 32'h1);
		cyc(12);
		chk({31'h0, hiz}, 32'h0);
	endtask

	task t_lock;
		int n;
		apb(1'b1, ADDR_CTRL, 32'h0);
		n = 0;
		while (lock !== 1'b1 && n < 80000) begin
			@(negedge clk_i);
			n++;
		end
		chk({31'h0, lock}, 32'h1);
		chk({29'h0, fc, fb, fa}, 32'h4);
		apb(1'b0, ADDR_IRQ_STAT, 32'h0);
		chk({31'h0, rd[0]}, 32'h1);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, ADDR_IRQ_MASK, 32'h1);
		cyc(3);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, ADDR_IRQ_STAT, 32'h1);
		cyc(3);
		chk({31'h0, irq}, 32'h0);
		apb(1'b0, ADDR_IRQ_STAT, 32'h0);
		chk({31'h0, rd[0]}, 32'h0);
		apb(1'b0, ADDR_IRQ_MASK, 32'h0);
		chk(rd, 32'h1);
	endtask

	// Leave normal mode briefly, come back on the same reference
	task t_exc(input logic [1:0] m, input logic h);
		apb(1'b0, ADDR_CORR, 32'h0);
		corr0 = rd;
		@(posedge clk_i);
		mode_req <= m;
		hitless_switch_select <= h;
		prof_req <= 2'b01;
		cyc(6);
		chk({31'h0, hold}, {31'h0, m == 2'b01});
		chk({31'h0, lock}, 32'h0);
		@(posedge clk_i);
		mode_req <= 2'b00;
		cyc(13000);
		chk({31'h0, fb}, 32'h1);
		apb(1'b0, ADDR_CORR, 32'h0);
		if (h) begin
			chk({31'h0, rd !== corr0}, 32'h1);
		end else begin
			chk(rd, corr0);
		end
	endtask

	task t_auto;
		@(posedge clk_i);
		mode_req <= 2'b11;
		cyc(6);
		chk({31'h0, hold}, 32'h0);
	endtask

	initial begin
		repeat (20) @(posedge clk_i);
		rstn_i <= 1'b1;
		t_reset;
		t_lock;
		t_exc(2'b01, 1'b0);
		t_exc(2'b10, 1'b1);
		t_auto;
		end_of_test;
	end

	initial begin
		#1000000;
		fail_count++;
		end_of_test;
	end
endmodule

// ### bench/dss_ref_model.sv
// Board side model: three reference clocks and held strap codes
`timescale 1ns/1ns
module dss_ref_model (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [15:0] per_a_i,
	input wire logic [15:0] per_b_i,
	input wire logic [15:0] per_c_i,
	input wire logic [15:0] step_c_i,
	input wire logic [1:0] mode_req_i,
	input wire logic [1:0] prof_req_i,
	output logic [2:0] ref_o,
	output logic [1:0] mode_o,
	output logic [1:0] prof_o
);
	logic [15:0] per [3];
	logic [15:0] cnt_r [3];
	logic alt_r;
	assign per[0] = per_a_i;
	assign per[1] = per_b_i;
	// Alternating period on c gives a steady run of abrupt changes
	assign per[2] = alt_r ? per_c_i + step_c_i : per_c_i;
	assign mode_o = mode_req_i;
	assign prof_o = prof_req_i;
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			for (int i = 0; i < 3; i++) begin
				cnt_r[i] <= 16'h0000;
			end
			alt_r <= 1'b0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				cnt_r[i] <= (cnt_r[i] >= per[i] - 16'h0001) ? 16'h0000 : cnt_r[i] + 16'h0001;
			end
			if (cnt_r[2] >= per[2] - 16'h0001) begin
				alt_r <= !alt_r;
			end
		end
	end
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			ref_o[i] = cnt_r[i] < {1'b0, per[i][15:1]};
		end
	end
endmodule

// ### hdl/dss_dpll_ctrl.sv
// Loop state, lock/holdover/failure indicators, hitless corrector control, APB registers
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
module dss_dpll_ctrl #(
	parameter int RESET_HOLD_CYC = dss_pkg::RESET_HOLD_CYC_DFLT
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [7:0] paddr_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic timing_input_a_i,
	input wire logic timing_input_b_i,
	input wire logic timing_input_c_i,
	input wire logic operating_mode_bit0_i,
	input wire logic operating_mode_bit1_i,
	input wire logic [1:0] application_profile_select_i,
	input wire logic hitless_switch_select_i,
	output logic lock_o,
	output logic holdover_o,
	output logic input_a_failure_flag_o,
	output logic input_b_failure_flag_o,
	output logic input_c_failure_flag_o,
	output logic clk_outputs_hiz_o,
	output logic irq_o
);
	import dss_pkg::*;

	localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(RESET_HOLD_CYC - 1);

	logic [SYNC_W-1:0] sync1_r;
	logic [SYNC_W-1:0] sync2_r;
	logic [HOLD_W-1:0] hold_cnt_r;
	dss_state_e state_r;
	dss_state_e st_nxt;
	dss_state_e tgt_st;
	logic [1:0] ctrl_ref_r;
	logic [1:0] act_ref_r;
	logic remeas_r;
	logic [PER_W-1:0] phase_r;
	logic [PER_W-1:0] corr_r;
	logic [2:0] lock_cnt_r;
	logic [2:0] lock_cnt_nxt;
	logic lock_r;
	logic hold_r;
	logic hiz_r;
	logic [NUM_REF-1:0] fail_r;
	logic [IRQ_W-1:0] irq_stat_r;
	logic [IRQ_W-1:0] irq_mask_r;
	logic irq_r;
	logic pready_r;
	logic pslverr_r;
	logic [31:0] prdata_r;

	// Pins are asynchronous to the master clock
	wire [SYNC_W-1:0] pin_w = {timing_input_c_i, timing_input_b_i, timing_input_a_i,
		operating_mode_bit1_i, operating_mode_bit0_i, application_profile_select_i,
		hitless_switch_select_i};

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= pin_w;
			sync2_r <= sync1_r;
		end
	end

	wire hms_q = sync2_r[0];
	wire [1:0] app_q = sync2_r[2:1];
	wire [1:0] mode_bits = sync2_r[4:3];
	wire [NUM_REF-1:0] ref_q = sync2_r[7:5];
	wire dss_mode_e mode_q = dss_mode_e'(mode_bits);

	// Reference monitors
	wire [NUM_REF-1:0] fail_w;
	wire [NUM_REF-1:0] edge_w;
	dss_ref_if ref_if[NUM_REF] ();

	for (genvar g = 0; g < NUM_REF; g++) begin : g_mon
		assign ref_if[g].lvl = ref_q[g];
		assign ref_if[g].app = app_q;
		assign fail_w[g] = ref_if[g].fail;
		assign edge_w[g] = ref_if[g].edge_p;
		dss_ref_mon u_mon (
			.clk_i(clk_i),
			.rstn_i(rstn_i),
			.bus(ref_if[g].mon)
		);
	end

	// Padded so a two-bit index never leaves the vector
	wire [3:0] fail4 = {1'b1, fail_w};
	wire [3:0] edge4 = {1'b0, edge_w};

	// Reference choice
	wire [1:0] auto_ref = !fail_w[0] ? REF_A : !fail_w[1] ? REF_B : !fail_w[2] ? REF_C : REF_NONE;
	wire [1:0] norm_ref = (ctrl_ref_r == REF_NONE) ? REF_C : ctrl_ref_r;
	wire [1:0] tgt_ref = (mode_q == MODE_AUTO) ? auto_ref : norm_ref;
	wire tgt_ok = !fail4[tgt_ref];
	wire tracking = (state_r == ST_NORMAL) || (state_r == ST_HOLDOVER);
	wire hold_done = hold_cnt_r == HOLD_LAST;
	wire act_fail = fail4[act_ref_r];
	wire act_edge = edge4[act_ref_r];

	// Loop state from the mode code; a lost reference with history goes to holdover
	always_comb begin
		case (mode_q)
			MODE_FREERUN: tgt_st = ST_FREERUN;
			MODE_HOLDOVER: tgt_st = ST_HOLDOVER;
			MODE_NORMAL,
			MODE_AUTO: tgt_st = tgt_ok ? ST_NORMAL : (tracking ? ST_HOLDOVER : ST_FREERUN);
			default: tgt_st = ST_FREERUN;
		endcase
	end

	always_comb begin
		case (state_r)
			ST_RESET: st_nxt = hold_done ? tgt_st : ST_RESET;
			ST_FREERUN,
			ST_NORMAL,
			ST_HOLDOVER: st_nxt = tgt_st;
			default: st_nxt = ST_RESET;
		endcase
	end

	// Hitless handling on the return to normal
	wire from_idle = (state_r == ST_HOLDOVER) || (state_r == ST_FREERUN);
	wire enter_norm = from_idle && (st_nxt == ST_NORMAL);
	wire same_ref = tgt_ref == act_ref_r;
	wire keep_corr = enter_norm && same_ref && !hms_q;
	wire ref_change = (state_r == ST_NORMAL) && (st_nxt == ST_NORMAL) && !same_ref;
	// Any other entry to normal or reference swap measures afresh
	wire start_meas = (st_nxt == ST_NORMAL) && ((state_r != ST_NORMAL) || !same_ref) && !keep_corr;
	wire cap = remeas_r && act_edge && (state_r == ST_NORMAL);
	wire phase_wrap = phase_r == (REF_NOM_PER - PER_ONE);

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_r <= ST_RESET;
			hold_cnt_r <= '0;
			act_ref_r <= REF_A;
		end else begin
			state_r <= st_nxt;
			hold_cnt_r <= (state_r == ST_RESET && !hold_done) ? hold_cnt_r + 1'b1 : hold_cnt_r;
			act_ref_r <= (st_nxt == ST_NORMAL) ? tgt_ref : act_ref_r;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			remeas_r <= 1'b0;
			corr_r <= '0;
			phase_r <= '0;
		end else begin
			remeas_r <= start_meas | (remeas_r & ~cap & ~keep_corr);
			corr_r <= cap ? phase_r : corr_r;
			phase_r <= phase_wrap ? '0 : phase_r + PER_ONE;
		end
	end

	// Lock needs a run of clean edges on the active reference
	always_comb begin
		if (st_nxt != ST_NORMAL || ref_change || act_fail)
			lock_cnt_nxt = '0;
		else if (act_edge && lock_cnt_r != LOCK_EDGES)
			lock_cnt_nxt = lock_cnt_r + LOCK_ONE;
		else
			lock_cnt_nxt = lock_cnt_r;
	end

	wire lock_nxt = (state_r == ST_NORMAL) && (lock_cnt_r == LOCK_EDGES) && !act_fail;
	wire hold_nxt = state_r == ST_HOLDOVER;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			lock_cnt_r <= '0;
			lock_r <= 1'b0;
			hold_r <= 1'b0;
			hiz_r <= 1'b1;
			fail_r <= '1;
		end else begin
			lock_cnt_r <= lock_cnt_nxt;
			lock_r <= lock_nxt;
			hold_r <= hold_nxt;
			hiz_r <= state_r == ST_RESET;
			fail_r <= fail_w;
		end
	end

	// Interrupt events: lock gained, lock lost, holdover entered, per-reference failure
	wire [IRQ_W-1:0] ev_w = {fail_w & ~fail_r, hold_nxt & ~hold_r, ~lock_nxt & lock_r, lock_nxt & ~lock_r};

	// APB slave, one wait state so every answer comes from a flip-flop
	wire acc = psel_i & penable_i;
	wire first = acc & ~pready_r;
	wire done = acc & pready_r;
	wire wr = done & pwrite_i;
	wire hit = (paddr_i == ADDR_CTRL) || (paddr_i == ADDR_STATUS) || (paddr_i == ADDR_IRQ_STAT) ||
		(paddr_i == ADDR_IRQ_MASK) || (paddr_i == ADDR_CORR);
	wire [IRQ_W-1:0] w1c = (wr && paddr_i == ADDR_IRQ_STAT) ? pwdata_i[IRQ_W-1:0] : '0;

	dss_status_s status_w;
	assign status_w = '{rsvd: '0, hiz: hiz_r, app: app_q, mode: mode_bits, st: state_r,
		fail: fail_r, hold: hold_r, lock: lock_r};

	wire [31:0] rd_w = (paddr_i == ADDR_CTRL) ? {30'h0, ctrl_ref_r} :
		(paddr_i == ADDR_STATUS) ? status_w :
		(paddr_i == ADDR_IRQ_STAT) ? {26'h0, irq_stat_r} :
		(paddr_i == ADDR_IRQ_MASK) ? {26'h0, irq_mask_r} :
		(paddr_i == ADDR_CORR) ? {16'h0, corr_r} : 32'h0;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= '0;
		end else begin
			pready_r <= first;
			pslverr_r <= first & ~hit;
			prdata_r <= (first && !pwrite_i) ? rd_w : prdata_r;
		end
	end

	// A new event wins over a same-cycle clear
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ctrl_ref_r <= REF_A;
			irq_mask_r <= '0;
			irq_stat_r <= '0;
			irq_r <= 1'b0;
		end else begin
			ctrl_ref_r <= (wr && paddr_i == ADDR_CTRL) ? pwdata_i[1:0] : ctrl_ref_r;
			irq_mask_r <= (wr && paddr_i == ADDR_IRQ_MASK) ? pwdata_i[IRQ_W-1:0] : irq_mask_r;
			irq_stat_r <= ev_w | (irq_stat_r & ~w1c);
			irq_r <= |(irq_stat_r & irq_mask_r);
		end
	end

	assign prdata_o = prdata_r;
	assign pready_o = pready_r;
	assign pslverr_o = pslverr_r;
	assign lock_o = lock_r;
	assign holdover_o = hold_r;
	assign input_a_failure_flag_o = fail_r[0];
	assign input_b_failure_flag_o = fail_r[1];
	assign input_c_failure_flag_o = fail_r[2];
	assign clk_outputs_hiz_o = hiz_r;
	assign irq_o = irq_r;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	a_lock_in_normal: assert property (lock_o |-> $past(state_r) == ST_NORMAL)
		else $error("lock outside normal");
	a_lock_after_run: assert property (state_r == ST_NORMAL && lock_cnt_r == LOCK_EDGES && !act_fail |=> lock_o)
		else $error("lock missing after edge run");
	a_hold_follows: assert property (state_r == ST_HOLDOVER |=> holdover_o)
		else $error("holdover indicator low in holdover");
	a_hold_only: assert property (state_r != ST_HOLDOVER |=> !holdover_o)
		else $error("holdover indicator high outside holdover");
	a_fail_mirror: assert property (fail_w != $past(fail_w) |=> fail_r == $past(fail_w))
		else $error("fail flag not following monitor");
	a_jump_to_flag: assert property (ref_if[0].edge_p ##1 1'b1 |-> ##[0:1] input_a_failure_flag_o == fail_w[0])
		else $error("flag a lags monitor");
	a_keep_delay: assert property (keep_corr |=> !remeas_r && $stable(corr_r))
		else $error("stored delay not kept");
	a_fresh_delay: assert property (enter_norm && same_ref && hms_q |=> remeas_r)
		else $error("no fresh measure on hitless return");
	a_other_ref: assert property (enter_norm && !same_ref |=> remeas_r)
		else $error("new reference not measured");
	a_freerun_mode: assert property (state_r != ST_RESET && mode_q == MODE_FREERUN |=> state_r == ST_FREERUN)
		else $error("freerun code not obeyed");
	a_reset_hold: assert property (state_r == ST_RESET && !hold_done |=> state_r == ST_RESET)
		else $error("reset state left early");
	a_hiz_reset: assert property (state_r == ST_RESET |=> clk_outputs_hiz_o)
		else $error("outputs not hi-z in reset state");
	a_sync_depth: assert property ($changed(hms_q) |-> hms_q == $past(hitless_switch_select_i, 2))
		else $error("synchroniser depth wrong");
	a_irq_level: assert property (irq_o |-> $past(|(irq_stat_r & irq_mask_r)))
		else $error("irq without unmasked status");

	c_lock_gain: cover property (!lock_o ##1 lock_o);
	c_holdover: cover property (state_r == ST_NORMAL ##1 state_r == ST_HOLDOVER);
	c_hitless: cover property (enter_norm && same_ref && hms_q);
	c_keep: cover property (keep_corr);
endmodule

// ### hdl/dss_pkg.sv
// Shared constants, types and helpers for the loop status and hitless control block
package dss_pkg;
	localparam int CLK_KHZ = 100000;
	localparam int RESET_STATE_MS = 3;
	localparam int RESET_HOLD_CYC_DFLT = RESET_STATE_MS * CLK_KHZ;
	localparam int HOLD_W = 19;
	localparam int NUM_REF = 3;
	localparam int SYNC_W = 8;
	localparam int PER_W = 16;
	localparam int IRQ_W = 6;
	localparam logic [PER_W-1:0] PER_ONE = 16'h0001;
	localparam logic [PER_W-1:0] PER_MAX = 16'hffff;
	// Nominal 8 kHz reference period in master clock cycles
	localparam logic [PER_W-1:0] REF_NOM_PER = 16'h30d4;
	localparam logic [PER_W-1:0] TOL_APP0 = 16'h0010;
	localparam logic [PER_W-1:0] TOL_APP1 = 16'h0008;
	localparam logic [PER_W-1:0] TOL_APP2 = 16'h0004;
	localparam logic [PER_W-1:0] TOL_APP3 = 16'h0004;
	localparam logic [PER_W-1:0] JUMP_LIM = 16'h0003;
	localparam logic [2:0] LOCK_EDGES = 3'h4;
	localparam logic [2:0] LOCK_ONE = 3'h1;
	localparam logic [1:0] REF_A = 2'h0;
	localparam logic [1:0] REF_B = 2'h1;
	localparam logic [1:0] REF_C = 2'h2;
	localparam logic [1:0] REF_NONE = 2'h3;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
	localparam logic [7:0] ADDR_CORR = 8'h10;
	typedef enum logic [1:0] {
		MODE_NORMAL = 2'b00,
		MODE_HOLDOVER = 2'b01,
		MODE_FREERUN = 2'b10,
		MODE_AUTO = 2'b11
	} dss_mode_e;
	typedef enum logic [1:0] {
		ST_RESET = 2'b00,
		ST_FREERUN = 2'b01,
		ST_NORMAL = 2'b10,
		ST_HOLDOVER = 2'b11
	} dss_state_e;
	typedef struct packed {
		logic [19:0] rsvd;
		logic hiz;
		logic [1:0] app;
		logic [1:0] mode;
		logic [1:0] st;
		logic [2:0] fail;
		logic hold;
		logic lock;
	} dss_status_s;
	function automatic logic [PER_W-1:0] absdiff(input logic [PER_W-1:0] a, input logic [PER_W-1:0] b);
		absdiff = (a > b) ? a - b : b - a;
	endfunction
	function automatic logic [PER_W-1:0] prof_tol(input logic [1:0] app);
		case (app)
			2'b00: prof_tol = TOL_APP0;
			2'b01: prof_tol = TOL_APP1;
			2'b10: prof_tol = TOL_APP2;
			default: prof_tol = TOL_APP3;
		endcase
	endfunction
endpackage

// ### hdl/dss_ref_if.sv
// Per-reference link between the loop controller and a reference monitor
`timescale 1ns/1ns
interface dss_ref_if;
	logic lvl;
	logic [1:0] app;
	logic fail;
	logic edge_p;
	modport mon (input lvl, input app, output fail, output edge_p);
	modport core (output lvl, output app, input fail, input edge_p);
endinterface

// ### hdl/dss_ref_mon.sv
// Reference monitor: period range, abrupt change and loss checks
`timescale 1ns/1ns
module dss_ref_mon (
	input wire logic clk_i,
	input wire logic rstn_i,
	dss_ref_if.mon bus
);
	import dss_pkg::*;
	logic lvl_d_r;
	logic [PER_W-1:0] cnt_r;
	logic [PER_W-1:0] prev_r;
	logic seen_r;
	logic fail_r;
	logic edge_r;
	wire rise = bus.lvl & ~lvl_d_r;
	wire [PER_W-1:0] tol = prof_tol(bus.app);
	wire oor = absdiff(cnt_r, REF_NOM_PER) > tol;
	wire jump = seen_r & (absdiff(cnt_r, prev_r) > JUMP_LIM);
	wire stuck = cnt_r == PER_MAX;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			lvl_d_r <= 1'b0;
			cnt_r <= PER_ONE;
			prev_r <= REF_NOM_PER;
			seen_r <= 1'b0;
			edge_r <= 1'b0;
		end else begin
			lvl_d_r <= bus.lvl;
			cnt_r <= rise ? PER_ONE : (stuck ? cnt_r : cnt_r + PER_ONE);
			prev_r <= rise ? cnt_r : prev_r;
			seen_r <= seen_r | rise;
			edge_r <= rise;
		end
	end

	// Unproven after reset; a lost reference stays failed until a clean period
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i)
			fail_r <= 1'b1;
		else if (stuck)
			fail_r <= 1'b1;
		else if (rise && seen_r)
			fail_r <= oor | jump;
	end

	assign bus.fail = fail_r;
	assign bus.edge_p = edge_r;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	a_fail_out_range: assert property (rise && seen_r && oor |=> fail_r) else $error("range fault not flagged");
	a_fail_on_jump: assert property (rise && jump && !stuck |=> fail_r) else $error("abrupt change not flagged");
	a_clean_clears: assert property (rise && seen_r && !oor && !jump && !stuck |=> !fail_r)
		else $error("clean period kept fail");
	c_fail_raised: cover property (rise && seen_r && oor);
endmodule
